/* hdl/fan_channel.sv */
// One fan: target count, speed regulation, PWM generation and stretching
`include "fan_ctrl_consts.svh"
module fan_channel (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Settings
  input wire fan_ctrl_pkg::fan_cfg_t i_cfg,
  input wire logic [7:0] i_start_cnt,
  input wire logic [7:0] i_ppr_min,
  input wire logic [1:0][7:0] i_temp,
  input wire logic [1:0][7:0] i_start_temp,
  // Host duty write
  input wire logic i_duty_wr,
  input wire logic [7:0] i_duty_wdata,
  // Tachometer measurement
  input wire logic i_meas_strobe,
  input wire logic [7:0] i_tach_period,
  // Results
  output logic [7:0] o_duty,
  output logic [7:0] o_target,
  output logic o_pwm,
  output logic o_stretching
);
  fan_ctrl_pkg::chan_state_t s_reg, s_next;
  logic manual_rpm, auto_rpm, engage;
  logic [7:0] raw_tgt, scaled;

  // Pulses per revolution: field value plus one
  function automatic logic [2:0] ppr_decode(input logic [1:0] f);
    ppr_decode = {1'b0, f} + 3'h1;
  endfunction

  // Count over the selected pulses, saturated to eight bits
  function automatic logic [7:0] scale_count(input logic [7:0] p, input logic [1:0] f);
    logic [10:0] prod;
    prod = p * ppr_decode(f);
    scale_count = (prod > 11'h0FF) ? 8'hFF : prod[7:0];
  endfunction

  always_comb begin
    manual_rpm = !i_cfg.pwm_mode && (i_cfg.chan_sel == 2'b00); // see RULE14
    auto_rpm = !i_cfg.pwm_mode && (i_cfg.chan_sel != 2'b00);
    // Unsigned compare, one-degree steps; either selected channel engages
    engage = (i_cfg.chan_sel[0] && (i_temp[0] >= i_start_temp[0])) ||
             (i_cfg.chan_sel[1] && (i_temp[1] >= i_start_temp[1])); // see RULE10 see RULE17
    scaled = scale_count(i_tach_period, i_ppr_min[`PPR_MSB:`PPR_LSB]); // see RULE4 see RULE5
    if (manual_rpm) begin
      raw_tgt = i_start_cnt; // see RULE3
    end else if (auto_rpm && engage) begin
      raw_tgt = i_start_cnt; // see RULE1
    end else if (auto_rpm && i_cfg.min_speed) begin
      raw_tgt = i_start_cnt; // see RULE2 see RULE15
    end else begin
      raw_tgt = 8'h00; // see RULE2 see RULE15
    end
    s_next = s_reg;
    // Zero target means no drive, so the floor does not lift it
    if (raw_tgt != 8'h00 && raw_tgt < {2'b00, i_ppr_min[`MINCNT_MSB:0]}) begin
      s_next.target = {2'b00, i_ppr_min[`MINCNT_MSB:0]}; // see RULE6
    end else begin
      s_next.target = raw_tgt;
    end
    if (i_duty_wr && i_cfg.pwm_mode) begin
      s_next.duty_tgt = i_duty_wdata; // see RULE9
    end
    if (i_meas_strobe) begin
      if (i_cfg.pwm_mode) begin
        if (s_reg.duty < s_reg.duty_tgt && s_reg.duty < `DUTY_MAX) begin
          s_next.duty = s_reg.duty + 8'h01;
        end else if (s_reg.duty > s_reg.duty_tgt) begin
          s_next.duty = s_reg.duty - 8'h01;
        end
      end else if (s_reg.target == 8'h00) begin
        s_next.duty = 8'h00;
      end else if (scaled > s_reg.target && s_reg.duty < `DUTY_MAX) begin
        s_next.duty = s_reg.duty + 8'h01; // see RULE3
      end else if (scaled < s_reg.target && s_reg.duty != 8'h00) begin
        s_next.duty = s_reg.duty - 8'h01;
      end
    end
    if (s_reg.tick_cnt == 8'((`TICK_DIV) - 1)) begin
      s_next.tick_cnt = 8'h00;
      if (s_reg.pwm_cnt == `PWM_STEPS - 7'h01) begin
        s_next.pwm_cnt = 7'h00;
        s_next.stretch_cnt = s_reg.stretch_cnt + 4'h1;
        // One whole period held on so tach edges can be counted
        s_next.stretching = (s_reg.stretch_cnt == `STRETCH_EVERY) && (s_reg.duty != 8'h00); // see RULE11
      end else begin
        s_next.pwm_cnt = s_reg.pwm_cnt + 7'h01;
      end
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 8'h01;
    end
    if (i_cfg.stretch_dis) begin
      s_next.stretching = 1'b0; // see RULE16
    end
    s_next.pwm = s_next.stretching || ({1'b0, s_next.pwm_cnt} < s_next.duty);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_duty = s_reg.duty;
  assign o_target = s_reg.target;
  assign o_pwm = s_reg.pwm;
  assign o_stretching = s_reg.stretching;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [7:0] floor_c;
  assign floor_c = {2'b00, i_ppr_min[`MINCNT_MSB:0]};

  property p_manual_target;
    @(posedge i_clk) disable iff (!i_rstn)
    (manual_rpm && i_start_cnt >= floor_c) |=> (s_reg.target == $past(i_start_cnt));
  endproperty
  a_manual_target: assert property (p_manual_target) else $error("manual target wrong"); // see RULE3

  property p_engage_start;
    @(posedge i_clk) disable iff (!i_rstn)
    (auto_rpm && engage && i_start_cnt >= floor_c) |=> (s_reg.target == $past(i_start_cnt));
  endproperty
  a_engage_start: assert property (p_engage_start) else $error("start count not applied"); // see RULE10

  property p_below_zero;
    @(posedge i_clk) disable iff (!i_rstn)
    (auto_rpm && !engage && !i_cfg.min_speed) |=> (s_reg.target == 8'h00);
  endproperty
  a_below_zero: assert property (p_below_zero) else $error("drive below fan start"); // see RULE15

  property p_below_min;
    @(posedge i_clk) disable iff (!i_rstn)
    (auto_rpm && !engage && i_cfg.min_speed && i_start_cnt >= floor_c)
      |=> (s_reg.target == $past(i_start_cnt));
  endproperty
  a_below_min: assert property (p_below_min) else $error("minimum speed lost"); // see RULE2

  property p_floor;
    @(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> (s_reg.target == 8'h00 || s_reg.target >= $past(floor_c));
  endproperty
  a_floor: assert property (p_floor) else $error("target under floor"); // see RULE6

  property p_speed_up;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_meas_strobe && !i_cfg.pwm_mode && s_reg.target != 8'h00 && scaled > s_reg.target
      && s_reg.duty < `DUTY_MAX) |=> (s_reg.duty == $past(s_reg.duty) + 8'h01);
  endproperty
  a_speed_up: assert property (p_speed_up) else $error("slow fan not sped up"); // see RULE3

  property p_pwm_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_duty_wr && i_cfg.pwm_mode) |=> (s_reg.duty_tgt == $past(i_duty_wdata));
  endproperty
  a_pwm_write: assert property (p_pwm_write) else $error("duty target not taken"); // see RULE9

  sequence s_dis_held;
    i_cfg.stretch_dis ##1 i_cfg.stretch_dis;
  endsequence
  property p_no_stretch;
    @(posedge i_clk) disable iff (!i_rstn)
    s_dis_held |-> !s_reg.stretching;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("stretch while disabled"); // see RULE16
endmodule // fan_channel

/* hdl/fan_ctrl_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef FAN_CTRL_CONSTS_SVH
`define FAN_CTRL_CONSTS_SVH
`define OFS_FAN1_START_CNT 8'h22
`define OFS_FAN2_START_CNT 8'h23
`define OFS_FAN1_PPR_MIN 8'h24
`define OFS_FAN2_PPR_MIN 8'h25
`define OFS_FAN1_DUTY 8'h26
`define OFS_FAN2_DUTY 8'h27
`define OFS_CHAN1_START_TEMP 8'h28
`define OFS_CHAN2_START_TEMP 8'h29
`define PPR_MSB 7
`define PPR_LSB 6
`define MINCNT_MSB 5
`define RST_START_CNT 8'h00
`define RST_PPR_MIN 8'h00
`define RST_DUTY 8'h00
`define RST_START_TEMP 8'h00
`define DUTY_MAX 8'h78
`define PWM_STEPS 7'h78
`define STRETCH_EVERY 4'hF
`define CLK_HZ 250000000
`define PWM_FREQ_HZ 25000
`define TICK_DIV ((`CLK_HZ) / ((`PWM_FREQ_HZ) * 120))
`endif

/* hdl/fan_ctrl_pkg.sv */
// Types shared by the fan speed-control block
package fan_ctrl_pkg;
  typedef struct packed {
    logic pwm_mode;
    logic [1:0] chan_sel;
    logic min_speed;
    logic stretch_dis;
  } fan_cfg_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] duty_tgt;
    logic [7:0] target;
    logic [6:0] pwm_cnt;
    logic [7:0] tick_cnt;
    logic [3:0] stretch_cnt;
    logic stretching;
    logic pwm;
  } chan_state_t;

  typedef struct packed {
    logic [1:0][7:0] start_cnt;
    logic [1:0][7:0] ppr_min;
    logic [1:0][7:0] start_temp;
    logic [7:0] rdata;
    logic ack;
  } regs_state_t;
endpackage

/* hdl/fan_ctrl_top.sv */
// Two-fan speed controller with its byte register file
// What the document requires
// RULE1: In automatic RPM mode the start count register is the starting tach count once control engages.
// RULE2: Below fan-start the target is the start count or zero, chosen by the minimum-speed bit.
// RULE3: In manual RPM mode the start count is the target count and duty is regulated toward it.
// RULE4: The pulses field 00..11 selects one to four tach pulses per revolution.
// RULE5: Counts are scaled so fans at equal speed give equal counts whatever their pulse count.
// RULE6: The six-bit minimum count floors the target so the fan stays under its top speed.
// RULE7: The host picks the range so the minimum count lies near 30 to 60, or full speed if uncapped.
// RULE8: Each duty register reads back the duty presently applied to its fan.
// RULE9: In PWM mode a host write to a duty register is the new target duty.
// RULE10: In automatic mode control begins when the channel temperature reaches its fan-start value.
// RULE11: Periodic pulse stretching is selectable, on or never.
// RULE12: The host starts automatic mode by writing 02h, 4Bh, 5Eh, 19h and lastly D2h to configuration 1; here chan_sel selects it, with no such register.
// RULE13: The mode bit high selects manual duty control, low selects RPM control.
// RULE14: With no temperature channel selected the fan runs in manual RPM mode at the target count.
// RULE15: Minimum-speed bit clear gives zero drive below fan-start; set, the start count sets the floor speed.
// RULE16: The stretch-disable bit stops stretching while speed is still measured.
// RULE17: Fan-start temperature compares unsigned in one-degree steps each measurement cycle.
`include "fan_ctrl_consts.svh"
module fan_ctrl_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Byte register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_ack,
  // Per-fan mode settings
  input wire fan_ctrl_pkg::fan_cfg_t i_fan1_cfg,
  input wire fan_ctrl_pkg::fan_cfg_t i_fan2_cfg,
  // Temperatures, unsigned degrees
  input wire logic [1:0][7:0] i_temp,
  // Tachometer measurement per fan
  input wire logic i_meas_strobe,
  input wire logic [1:0][7:0] i_tach_period,
  // Fan drive
  output logic [1:0] o_pwm,
  output logic [1:0] o_stretching,
  output logic [1:0][7:0] o_target
);
  fan_ctrl_pkg::regs_state_t r_reg, r_next;
  logic [1:0][7:0] duty;
  logic [1:0] duty_wr;
  fan_ctrl_pkg::fan_cfg_t cfg [2];

  assign cfg[0] = i_fan1_cfg;
  assign cfg[1] = i_fan2_cfg;

  // ************************************************************
  // Register file
  // ************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.ack = i_reg_wr || i_reg_rd;
    duty_wr = 2'b00;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `OFS_FAN1_START_CNT: r_next.start_cnt[0] = i_reg_wdata;
        `OFS_FAN2_START_CNT: r_next.start_cnt[1] = i_reg_wdata;
        `OFS_FAN1_PPR_MIN: r_next.ppr_min[0] = i_reg_wdata;
        `OFS_FAN2_PPR_MIN: r_next.ppr_min[1] = i_reg_wdata;
        // Ignored by the channel outside PWM mode
        `OFS_FAN1_DUTY: duty_wr[0] = 1'b1; // see RULE9
        `OFS_FAN2_DUTY: duty_wr[1] = 1'b1; // see RULE9
        `OFS_CHAN1_START_TEMP: r_next.start_temp[0] = i_reg_wdata;
        `OFS_CHAN2_START_TEMP: r_next.start_temp[1] = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `OFS_FAN1_START_CNT: r_next.rdata = r_reg.start_cnt[0];
        `OFS_FAN2_START_CNT: r_next.rdata = r_reg.start_cnt[1];
        `OFS_FAN1_PPR_MIN: r_next.rdata = r_reg.ppr_min[0];
        `OFS_FAN2_PPR_MIN: r_next.rdata = r_reg.ppr_min[1];
        // Present duty, not the written target
        `OFS_FAN1_DUTY: r_next.rdata = duty[0]; // see RULE8
        `OFS_FAN2_DUTY: r_next.rdata = duty[1]; // see RULE8
        `OFS_CHAN1_START_TEMP: r_next.rdata = r_reg.start_temp[0];
        `OFS_CHAN2_START_TEMP: r_next.rdata = r_reg.start_temp[1];
        default: r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      r_reg.start_cnt <= {`RST_START_CNT, `RST_START_CNT};
      r_reg.ppr_min <= {`RST_PPR_MIN, `RST_PPR_MIN};
      r_reg.start_temp <= {`RST_START_TEMP, `RST_START_TEMP};
      r_reg.rdata <= 8'h00;
      r_reg.ack <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_reg_rdata = r_reg.rdata;
  assign o_reg_ack = r_reg.ack;

  // ************************************************************
  // Fan channels
  // ************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_fan
    fan_channel u_chan (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_cfg(cfg[g]), // see RULE13
      .i_start_cnt(r_reg.start_cnt[g]),
      .i_ppr_min(r_reg.ppr_min[g]),
      .i_temp(i_temp),
      .i_start_temp(r_reg.start_temp),
      .i_duty_wr(duty_wr[g]),
      .i_duty_wdata(i_reg_wdata),
      .i_meas_strobe(i_meas_strobe),
      .i_tach_period(i_tach_period[g]),
      .o_duty(duty[g]),
      .o_target(o_target[g]),
      .o_pwm(o_pwm[g]),
      .o_stretching(o_stretching[g])
    );
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_read_duty;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && !i_reg_wr && i_reg_addr == `OFS_FAN1_DUTY)
      |=> (o_reg_ack && o_reg_rdata == $past(duty[0]));
  endproperty
  a_read_duty: assert property (p_read_duty) else $error("duty readback wrong"); // see RULE8

  property p_start_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == `OFS_FAN2_START_CNT)
      |=> (r_reg.start_cnt[1] == $past(i_reg_wdata)) ##1 (o_reg_ack == $past(i_reg_wr || i_reg_rd));
  endproperty
  a_start_write: assert property (p_start_write) else $error("start count not stored"); // see RULE1

  property p_unmapped;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && (i_reg_addr < `OFS_FAN1_START_CNT || i_reg_addr > `OFS_CHAN2_START_TEMP))
      |=> (o_reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_ack_follows;
    @(posedge i_clk) disable iff (!i_rstn)
    1'b1
      |=> (o_reg_ack == $past(i_reg_wr || i_reg_rd));
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack not one cycle after request");

  property p_rdata_hold;
    @(posedge i_clk) disable iff (!i_rstn)
    (!i_reg_rd)
      |=> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

  property p_read_duty2;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && !i_reg_wr && i_reg_addr == `OFS_FAN2_DUTY)
      |=> (o_reg_ack && o_reg_rdata == $past(duty[1]));
  endproperty
  a_read_duty2: assert property (p_read_duty2) else $error("fan2 duty readback wrong"); // see RULE8

  property p_read_start1;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && !i_reg_wr && i_reg_addr == `OFS_FAN1_START_CNT)
      |=> (o_reg_rdata == $past(r_reg.start_cnt[0]));
  endproperty
  a_read_start1: assert property (p_read_start1) else $error("start count readback wrong"); // see RULE3

  property p_start1_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == `OFS_FAN1_START_CNT)
      |=> (r_reg.start_cnt[0] == $past(i_reg_wdata));
  endproperty
  a_start1_write: assert property (p_start1_write) else $error("fan1 start count lost"); // see RULE1

  property p_ppr1_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == `OFS_FAN1_PPR_MIN)
      |=> (r_reg.ppr_min[0] == $past(i_reg_wdata));
  endproperty
  a_ppr1_write: assert property (p_ppr1_write) else $error("pulses setting lost"); // see RULE4

  property p_temp1_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == `OFS_CHAN1_START_TEMP)
      |=> (r_reg.start_temp[0] == $past(i_reg_wdata));
  endproperty
  a_temp1_write: assert property (p_temp1_write) else $error("ch1 start temp lost"); // see RULE10

  property p_temp2_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == `OFS_CHAN2_START_TEMP)
      |=> (r_reg.start_temp[1] == $past(i_reg_wdata));
  endproperty
  a_temp2_write: assert property (p_temp2_write) else $error("ch2 start temp lost"); // see RULE10

  // Stray writes must leave every stored setting alone
  property p_unmapped_write;
    @(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && (i_reg_addr < `OFS_FAN1_START_CNT || i_reg_addr > `OFS_CHAN2_START_TEMP))
      |=> ($stable(r_reg.start_cnt) && $stable(r_reg.ppr_min) && $stable(r_reg.start_temp));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");
endmodule // fan_ctrl_top

/* testbench/fan_model.sv */
// Behavioural cooling fan with tachometer, reporting one period per request
module fan_model (
  // Clock
  input wire logic i_clk,
  // Measurement request and present fan speed
  input wire logic i_meas_req,
  input wire logic [1:0][7:0] i_speed_period,
  // Tachometer result
  output logic o_meas_strobe,
  output logic [1:0][7:0] o_tach_period
);
  timeunit 1ns;
  timeprecision 1ps;
  // Period is only valid with the strobe; inverted otherwise so stale data cannot pass
  always_ff @(posedge i_clk) begin
    o_meas_strobe <= i_meas_req;
    o_tach_period <= i_meas_req ? i_speed_period : ~i_speed_period;
  end
endmodule // fan_model

/* testbench/testbench.sv */
// Self-checking bench for the two-fan speed controller
`include "fan_ctrl_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr, rd, ack, req, strobe;
  logic [7:0] addr, wdata, rdata;
  fan_ctrl_pkg::fan_cfg_t cfg1, cfg2;
  logic [1:0][7:0] temp, speed, period, target;
  logic [1:0] pwm, strch;
  int num_errors, comparisons, cycles;

  fan_ctrl_top u_fan_ctrl_top (.i_clk(clk), .i_rstn(rstn), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_fan1_cfg(cfg1), .i_fan2_cfg(cfg2), .i_temp(temp), .i_meas_strobe(strobe),
    .i_tach_period(period), .o_pwm(pwm), .o_stretching(strch), .o_target(target));
  fan_model u_fan_model (.i_clk(clk), .i_meas_req(req), .i_speed_period(speed),
    .o_meas_strobe(strobe), .o_tach_period(period));

  // ****************
  // Helpers
  // ****************
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 0;
    rd = 0;
    while (ack !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    check8("reg ack", 8'h01, {7'h00, ack});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_op(1'b0, a, 8'h00);
    check8(what, exp, rdata);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  // One tach measurement at the given period on both fans
  task automatic measure(input logic [7:0] p);
    @(negedge clk);
    speed = {p, p};
    req = 1;
    @(negedge clk);
    req = 0;
    settle();
  endtask
  // One whole PWM period; too early in the run for any stretch to fall due
  task automatic pwm_window(input logic [7:0] d1, input logic [7:0] d2);
    logic [15:0] hi1, hi2, st;
    hi1 = 16'h0000;
    hi2 = 16'h0000;
    st = 16'h0000;
    repeat (`PWM_STEPS * `TICK_DIV) begin
      @(negedge clk);
      hi1 = hi1 + 16'(pwm[0]);
      hi2 = hi2 + 16'(pwm[1]);
      st = st + 16'(strch[0]) + 16'(strch[1]);
    end
    check16("fan1 high time", 16'(d1 * `TICK_DIV), hi1);
    check16("fan2 high time", 16'(d2 * `TICK_DIV), hi2);
    check16("stretch time", 16'h0000, st);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    reg_op(1'b1, 8'h2A, 8'hFF);
    for (int a = 8'h22; a <= 8'h2A; a++) rd_chk(8'(a), 8'h00, "reset reg");
    check8("reset target", 8'h00, target[0]);
  endtask
  task automatic t_manual_rpm;
    reg_op(1'b1, 8'h22, 8'h4B);
    reg_op(1'b1, 8'h24, 8'h5E);
    settle();
    check8("manual target", 8'h4B, target[0]);
    rd_chk(8'h22, 8'h4B, "start count");
    reg_op(1'b1, 8'h22, 8'h10);
    settle();
    check8("floored target", 8'h1E, target[0]);
    reg_op(1'b1, 8'h23, 8'h37);
    settle();
    check8("fan2 target", 8'h37, target[1]);
    reg_op(1'b1, 8'h22, 8'h4B);
  endtask
  task automatic t_auto;
    reg_op(1'b1, 8'h28, 8'h19);
    reg_op(1'b1, 8'h29, 8'h40);
    @(negedge clk);
    temp = {8'h3F, 8'h18};
    cfg1.chan_sel = 2'b01;
    cfg2.chan_sel = 2'b10;
    settle();
    check8("below start", 8'h00, target[0]);
    check8("fan2 below start", 8'h00, target[1]);
    @(negedge clk);
    temp = {8'h40, 8'h19};
    settle();
    check8("at start", 8'h4B, target[0]);
    check8("fan2 at start", 8'h37, target[1]);
    @(negedge clk);
    temp[0] = 8'h18;
    cfg1.min_speed = 1;
    settle();
    check8("min speed", 8'h4B, target[0]);
    @(negedge clk);
    temp = {8'h40, 8'h18};
    cfg1.chan_sel = 2'b11;
    cfg1.min_speed = 0;
    settle();
    check8("either channel", 8'h4B, target[0]);
    @(negedge clk);
    temp[0] = 8'h19;
    cfg1.chan_sel = 2'b01;
  endtask
  // Period 19h scaled by 4..1 pulses straddles the 4Bh target
  task automatic t_scaling;
    logic [7:0] duty;
    logic [9:0] scaled;
    duty = 8'h00;
    for (int k = 3; k >= 0; k--) begin
      reg_op(1'b1, 8'h24, {2'(k), 6'h1E});
      settle();
      measure(8'h19);
      scaled = 10'h019 * 10'(k + 1);
      if (scaled > 10'h04B) duty++;
      else if (scaled < 10'h04B && duty != 8'h00) duty--;
      rd_chk(8'h26, duty, "scaled duty");
    end
  endtask
  task automatic t_pwm;
    reg_op(1'b1, 8'h26, 8'h50);
    @(negedge clk);
    cfg1.pwm_mode = 1;
    // A taken write would now step the duty up
    measure(8'h19);
    rd_chk(8'h26, 8'h00, "duty write refused");
    @(negedge clk);
    cfg1.stretch_dis = 1;
    reg_op(1'b1, 8'h26, 8'h03);
    for (int i = 1; i <= 4; i++) begin
      measure(8'h19);
      rd_chk(8'h26, (i > 3) ? 8'h03 : 8'(i), "pwm duty");
    end
    pwm_window(8'h03, 8'h00);
  endtask

  // ****************
  // Run control
  // ****************
  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // Whole run is about ten thousand cycles, mostly one PWM period
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rstn = 0;
    wr = 0;
    rd = 0;
    req = 0;
    addr = 8'h00;
    wdata = 8'h00;
    cfg1 = '0;
    cfg2 = '0;
    temp = '0;
    speed = '0;
    repeat (10) @(negedge clk);
    rstn = 1;
    t_reset();
    t_manual_rpm();
    t_auto();
    t_scaling();
    t_pwm();
    tally_and_finish();
  end
endmodule // testbench
